/* File: rtl/rslt_pkg.sv */
// Purpose: shared constants and types for the relay scheme logic timers
// Assumes: 40 MHz clock, settings held in 8-bit registers
// Notes: register indices are small word addresses on the plain port
package rslt_pkg;
   localparam int CLK_PERIOD_NS = 25;
   localparam int MS_NS = 1000000;
   localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int NUM_TIMERS = 7;
   // timer slots
   localparam int T_BRK1 = 0;
   localparam int T_BRK2 = 1;
   localparam int T_CFG = 2;
   localparam int T_TRIP = 3;
   localparam int T_PERM = 4;
   localparam int T_WEAK = 5;
   localparam int T_RO = 6;
   // register indices
   localparam logic [3:0] A_BRK1_PU = 4'h0;
   localparam logic [3:0] A_BRK1_DO = 4'h1;
   localparam logic [3:0] A_BRK2_PU = 4'h2;
   localparam logic [3:0] A_BRK2_DO = 4'h3;
   localparam logic [3:0] A_CFG_PU = 4'h4;
   localparam logic [3:0] A_CFG_DO = 4'h5;
   localparam logic [3:0] A_OUT4_SEL = 4'h6;
   localparam logic [3:0] A_TRIP_PU = 4'h7;
   localparam logic [3:0] A_PERM_PU = 4'h8;
   localparam logic [3:0] A_PERM_DO = 4'h9;
   localparam logic [3:0] A_WEAK_PU = 4'ha;
   localparam logic [3:0] A_RO_EN = 4'hb;
   localparam logic [3:0] A_RO_DLY = 4'hc;
   localparam logic [3:0] A_RCL_MODE = 4'hd;
   localparam logic [3:0] A_SCHEME = 4'he;
   localparam logic [3:0] A_STATUS = 4'hf;
   // setting ranges in ms
   localparam logic [7:0] BRK_MIN = 8'h00;
   localparam logic [7:0] BRK_MAX = 8'hc8;
   localparam logic [7:0] CFG_MIN = 8'h00;
   localparam logic [7:0] CFG_MAX = 8'h64;
   localparam logic [7:0] CFG_FIXED_DO = 8'h19;
   localparam logic [7:0] TRIP_MIN = 8'h01;
   localparam logic [7:0] TRIP_MAX = 8'h32;
   localparam logic [7:0] PERM_MIN = 8'h00;
   localparam logic [7:0] PERM_MAX = 8'h32;
   localparam logic [7:0] WEAK_MIN = 8'h08;
   localparam logic [7:0] WEAK_MAX = 8'h63;
   localparam logic [7:0] RO_MIN = 8'h0a;
   localparam logic [7:0] RO_MAX = 8'h64;
   localparam logic [7:0] RO_DLY_RST = 8'h28;
   localparam logic [7:0] ZERO_MS = 8'h00;
   // scheme and status register fields
   localparam int SCH_Z1EXT = 0;
   localparam int SCH_Z2U_LO = 1;
   localparam int SCH_Z2U_HI = 2;
   localparam int STAT_SEAL = 7;

   typedef enum logic [2:0] {
      RSLT_OUT4_OFF, RSLT_OUT4_U1, RSLT_OUT4_U2, RSLT_OUT4_U3, RSLT_OUT4_U4
   } rslt_out4_type;

   // same-clock inputs from the scheme logic
   typedef struct packed {
      logic trip_integrator_in;
      logic permissive_in;
      logic weak_infeed_in;
      logic remote_open_in;
      logic cfg_out_in;
      logic trip_request;
   } rslt_in_type;

   typedef struct packed {
      logic brk1_coord_timer;
      logic brk2_coord_timer;
      logic cfg_out_four;
      logic trip_integrator_timer;
      logic permissive_coord_timer;
      logic weak_infeed_timer;
      logic remote_open_timer;
      logic brk1_open_to_scheme;
      logic recloser_contact;
      logic distance_supervision;
      logic trip_bus_seal;
      logic [1:0] zone2_ground_unit;
   } rslt_out_type;

   typedef struct packed {
      logic valid;
      logic brk1_change;
      logic brk1_open;
      logic brk2_change;
      logic brk2_open;
      logic [31:0] stamp_ms;
   } rslt_event_type;
endpackage

/* File: rtl/rslt_timers.sv */
// Purpose: pickup/dropout scheme timers, contact routing, breaker events
// Assumes: contact and detector pins are asynchronous to i_mclk
// Notes: delay settings are clamped to their legal range on write
`timescale 1ns/1ps

// Notes on behaviour
// [R1] breaker one pickup settable 0 to 200 ms
// [R2] breaker one dropout settable 0 to 200 ms
// [R3] breaker two pickup settable 0 to 200 ms
// [R4] breaker two dropout settable 0 to 200 ms
// [R5] timer asserts on open, clears on close
// [R6] breaker timer changes make time-tagged events
// [R7] recloser off: contact one feeds timer directly
// [R8] recloser on: contact one to recloser, reporting
// [R9] zone-one extension ignores breaker timers for tripping
// [R10] output four pickup used for usage 1-4
// [R11] output four dropout setting only usage 1-2
// [R12] usage 3 or 4 forces 25 ms dropout
// [R13] trip integrator pickup 1 to 50 ms
// [R14] permissive pickup settable 0 to 50 ms
// [R15] permissive dropout settable 0 to 50 ms
// [R16] weak-infeed pickup settable 8 to 99 ms
// [R17] remote-open disabled gives no output
// [R18] remote-open delay 10 to 100 ms
// [R19] supervision detector gates distance and seal-in
// [R20] zone-one extension ignores ground unit select
// [R21] millisecond tick, count restarts on input change
module rslt_timers #(
   parameter int P_TICK_CYCLES = rslt_pkg::TICK_CYCLES
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic [rslt_pkg::ADDR_W-1:0] i_addr,
   input wire logic [rslt_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_contact_input_one,
   input wire logic i_contact_input_two,
   input wire logic i_trip_supervision_detector,
   input wire rslt_pkg::rslt_in_type i_sch,
   output logic [rslt_pkg::DATA_W-1:0] o_rdata,
   output rslt_pkg::rslt_out_type o_out,
   output rslt_pkg::rslt_event_type o_event
);
   localparam int NT = rslt_pkg::NUM_TIMERS;

   logic [7:0] brk1_pu, brk1_do, brk2_pu, brk2_do;
   logic [7:0] cfg_pu, cfg_do, trip_pu, perm_pu, perm_do;
   logic [7:0] weak_pu, ro_dly;
   logic ro_en;
   logic [2:0] out4_sel;
   logic [2:0] rcl_mode;
   logic [2:0] scheme;
   logic [2:0] sync1, sync2;
   logic [15:0] tick_cnt;
   logic tick;
   logic [31:0] ms_now;
   logic [NT-1:0] tin, tout;
   logic [7:0] pu [NT];
   logic [7:0] dn [NT];
   logic [7:0] cnt [NT];
   logic rcl_on, z1ext, c1, c2, it;

   function automatic logic [7:0] clamp(input logic [7:0] v,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   // setting registers, delays clamped into range on write
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         brk1_pu <= rslt_pkg::BRK_MIN;
         brk1_do <= rslt_pkg::BRK_MIN;
         brk2_pu <= rslt_pkg::BRK_MIN;
         brk2_do <= rslt_pkg::BRK_MIN;
         cfg_pu <= rslt_pkg::CFG_MIN;
         cfg_do <= rslt_pkg::CFG_MIN;
         out4_sel <= 3'h0;
         trip_pu <= rslt_pkg::TRIP_MIN;
         perm_pu <= rslt_pkg::PERM_MIN;
         perm_do <= rslt_pkg::PERM_MIN;
         weak_pu <= rslt_pkg::WEAK_MIN;
         ro_en <= 1'b0;
         ro_dly <= rslt_pkg::RO_DLY_RST;
         rcl_mode <= 3'h0;
         scheme <= 3'h0;
      end
      else if (i_wr)
      begin
         case (i_addr)
            rslt_pkg::A_BRK1_PU: brk1_pu <= clamp(i_wdata, // R1
               rslt_pkg::BRK_MIN, rslt_pkg::BRK_MAX);
            rslt_pkg::A_BRK1_DO: brk1_do <= clamp(i_wdata, // R2
               rslt_pkg::BRK_MIN, rslt_pkg::BRK_MAX);
            rslt_pkg::A_BRK2_PU: brk2_pu <= clamp(i_wdata, // R3
               rslt_pkg::BRK_MIN, rslt_pkg::BRK_MAX);
            rslt_pkg::A_BRK2_DO: brk2_do <= clamp(i_wdata, // R4
               rslt_pkg::BRK_MIN, rslt_pkg::BRK_MAX);
            rslt_pkg::A_CFG_PU: cfg_pu <= clamp(i_wdata,
               rslt_pkg::CFG_MIN, rslt_pkg::CFG_MAX);
            rslt_pkg::A_CFG_DO: cfg_do <= clamp(i_wdata,
               rslt_pkg::CFG_MIN, rslt_pkg::CFG_MAX);
            rslt_pkg::A_OUT4_SEL: out4_sel <= i_wdata[2:0];
            rslt_pkg::A_TRIP_PU: trip_pu <= clamp(i_wdata, // R13
               rslt_pkg::TRIP_MIN, rslt_pkg::TRIP_MAX);
            rslt_pkg::A_PERM_PU: perm_pu <= clamp(i_wdata, // R14
               rslt_pkg::PERM_MIN, rslt_pkg::PERM_MAX);
            rslt_pkg::A_PERM_DO: perm_do <= clamp(i_wdata, // R15
               rslt_pkg::PERM_MIN, rslt_pkg::PERM_MAX);
            rslt_pkg::A_WEAK_PU: weak_pu <= clamp(i_wdata, // R16
               rslt_pkg::WEAK_MIN, rslt_pkg::WEAK_MAX);
            rslt_pkg::A_RO_EN: ro_en <= i_wdata[0];
            rslt_pkg::A_RO_DLY: ro_dly <= clamp(i_wdata, // R18
               rslt_pkg::RO_MIN, rslt_pkg::RO_MAX);
            rslt_pkg::A_RCL_MODE: rcl_mode <= i_wdata[2:0];
            rslt_pkg::A_SCHEME: scheme <= i_wdata[2:0];
            default: ;
         endcase
      end
   end

   // read port, data one cycle after the strobe, zero otherwise
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         o_rdata <= 8'h00;
      else if (!i_rd)
         o_rdata <= 8'h00;
      else
      begin
         case (i_addr)
            rslt_pkg::A_BRK1_PU: o_rdata <= brk1_pu;
            rslt_pkg::A_BRK1_DO: o_rdata <= brk1_do;
            rslt_pkg::A_BRK2_PU: o_rdata <= brk2_pu;
            rslt_pkg::A_BRK2_DO: o_rdata <= brk2_do;
            rslt_pkg::A_CFG_PU: o_rdata <= cfg_pu;
            rslt_pkg::A_CFG_DO: o_rdata <= cfg_do;
            rslt_pkg::A_OUT4_SEL: o_rdata <= {5'h00, out4_sel};
            rslt_pkg::A_TRIP_PU: o_rdata <= trip_pu;
            rslt_pkg::A_PERM_PU: o_rdata <= perm_pu;
            rslt_pkg::A_PERM_DO: o_rdata <= perm_do;
            rslt_pkg::A_WEAK_PU: o_rdata <= weak_pu;
            rslt_pkg::A_RO_EN: o_rdata <= {7'h00, ro_en};
            rslt_pkg::A_RO_DLY: o_rdata <= ro_dly;
            rslt_pkg::A_RCL_MODE: o_rdata <= {5'h00, rcl_mode};
            rslt_pkg::A_SCHEME: o_rdata <= {5'h00, scheme};
            rslt_pkg::A_STATUS:
               o_rdata <= {o_out.trip_bus_seal, tout[NT-1:0]};
            default: o_rdata <= 8'h00;
         endcase
      end
   end

   // two-stage synchroniser for contacts and supervision detector
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
      end
      else
      begin
         sync1 <= {i_trip_supervision_detector, i_contact_input_two,
                   i_contact_input_one};
         sync2 <= sync1;
      end
   end

   // millisecond tick and running time stamp
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         tick_cnt <= 16'h0000;
         tick <= 1'b0;
         ms_now <= 32'h0000_0000;
      end
      else if (tick_cnt == 16'(P_TICK_CYCLES - 1))
      begin
         tick_cnt <= 16'h0000;
         tick <= 1'b1; // R21
         ms_now <= ms_now + 32'h0000_0001;
      end
      else
      begin
         tick_cnt <= tick_cnt + 16'h0001;
         tick <= 1'b0;
      end
   end

   // timer inputs and delays per slot
   assign c1 = sync2[0];
   assign c2 = sync2[1];
   assign it = sync2[2];
   assign rcl_on = (rcl_mode == 3'h3) || (rcl_mode == 3'h6);
   assign z1ext = scheme[rslt_pkg::SCH_Z1EXT];

   always_comb
   begin
      tin[rslt_pkg::T_BRK1] = c1; // R5 R7
      tin[rslt_pkg::T_BRK2] = c2; // R5
      tin[rslt_pkg::T_CFG] = i_sch.cfg_out_in;
      tin[rslt_pkg::T_TRIP] = i_sch.trip_integrator_in;
      tin[rslt_pkg::T_PERM] = i_sch.permissive_in;
      tin[rslt_pkg::T_WEAK] = i_sch.weak_infeed_in;
      tin[rslt_pkg::T_RO] = i_sch.remote_open_in & ro_en; // R17
      pu[rslt_pkg::T_BRK1] = brk1_pu;
      dn[rslt_pkg::T_BRK1] = brk1_do;
      pu[rslt_pkg::T_BRK2] = brk2_pu;
      dn[rslt_pkg::T_BRK2] = brk2_do;
      pu[rslt_pkg::T_TRIP] = trip_pu;
      dn[rslt_pkg::T_TRIP] = rslt_pkg::ZERO_MS;
      pu[rslt_pkg::T_PERM] = perm_pu;
      dn[rslt_pkg::T_PERM] = perm_do;
      pu[rslt_pkg::T_WEAK] = weak_pu;
      dn[rslt_pkg::T_WEAK] = rslt_pkg::ZERO_MS;
      pu[rslt_pkg::T_RO] = ro_dly; // R18
      dn[rslt_pkg::T_RO] = rslt_pkg::ZERO_MS;
      case (out4_sel)
         rslt_pkg::RSLT_OUT4_U1, rslt_pkg::RSLT_OUT4_U2:
         begin
            pu[rslt_pkg::T_CFG] = cfg_pu; // R10
            dn[rslt_pkg::T_CFG] = cfg_do; // R11
         end
         rslt_pkg::RSLT_OUT4_U3, rslt_pkg::RSLT_OUT4_U4:
         begin
            pu[rslt_pkg::T_CFG] = cfg_pu; // R10
            dn[rslt_pkg::T_CFG] = rslt_pkg::CFG_FIXED_DO; // R12
         end
         default:
         begin
            pu[rslt_pkg::T_CFG] = rslt_pkg::ZERO_MS;
            dn[rslt_pkg::T_CFG] = rslt_pkg::ZERO_MS;
         end
      endcase
   end

   // pickup/dropout counters, restarted whenever the input agrees again
   for (genvar g = 0; g < NT; g++)
   begin : g_tmr
      logic [7:0] dly;
      // delay for the change now pending
      assign dly = tin[g] ? pu[g] : dn[g];

      always_ff @(posedge i_mclk)
      begin
         if (!i_rst_n)
         begin
            cnt[g] <= 8'h00;
            tout[g] <= 1'b0;
         end
         else if (tin[g] == tout[g])
            cnt[g] <= 8'h00; // R21
         // N ms takes N+1 ticks, the first may come early
         else if (dly == rslt_pkg::ZERO_MS || cnt[g] > dly)
         begin
            tout[g] <= tin[g]; // R5
            cnt[g] <= 8'h00;
         end
         else if (tick)
            cnt[g] <= cnt[g] + 8'h01; // R21
      end
   end

   // registered outputs toward contacts and scheme logic
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         o_out <= '0;
      else
      begin
         o_out.brk1_coord_timer <= tout[rslt_pkg::T_BRK1];
         o_out.brk2_coord_timer <= tout[rslt_pkg::T_BRK2];
         o_out.cfg_out_four <= tout[rslt_pkg::T_CFG];
         o_out.trip_integrator_timer <= tout[rslt_pkg::T_TRIP];
         o_out.permissive_coord_timer <= tout[rslt_pkg::T_PERM];
         o_out.weak_infeed_timer <= tout[rslt_pkg::T_WEAK];
         o_out.remote_open_timer <= tout[rslt_pkg::T_RO] & ro_en; // R17
         o_out.brk1_open_to_scheme <=
            tout[rslt_pkg::T_BRK1] & !rcl_on & !z1ext; // R8 R9
         o_out.recloser_contact <= c1 & rcl_on; // R8
         o_out.distance_supervision <= it; // R19
         o_out.trip_bus_seal <= it &
            (i_sch.trip_request | o_out.trip_bus_seal); // R19
         o_out.zone2_ground_unit <= z1ext ? 2'h0 :
            scheme[rslt_pkg::SCH_Z2U_HI:rslt_pkg::SCH_Z2U_LO]; // R20
      end
   end

   // time-tagged breaker open/closed events
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         o_event <= '0;
      else
      begin
         o_event.brk1_change <= tout[0] != o_out.brk1_coord_timer; // R6
         o_event.brk2_change <= tout[1] != o_out.brk2_coord_timer; // R6
         o_event.valid <= (tout[0] != o_out.brk1_coord_timer) ||
                          (tout[1] != o_out.brk2_coord_timer);
         o_event.brk1_open <= tout[rslt_pkg::T_BRK1];
         o_event.brk2_open <= tout[rslt_pkg::T_BRK2];
         o_event.stamp_ms <= ms_now;
      end
   end

   // checks
   chk_ro_off: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      !ro_en |=> !o_out.remote_open_timer) // R17
      else $error("remote open active while disabled");
   chk_cfg_fixed_do: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n) (out4_sel == 3'h3 || out4_sel == 3'h4)
      |-> dn[rslt_pkg::T_CFG] == 8'h19) // R12
      else $error("output four dropout not fixed");
   chk_cfg_user_do: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n) (out4_sel == 3'h1 || out4_sel == 3'h2)
      |-> dn[rslt_pkg::T_CFG] == cfg_do) // R11
      else $error("output four dropout setting ignored");
   chk_cfg_pickup: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n) (out4_sel >= 3'h1 && out4_sel <= 3'h4)
      |-> pu[rslt_pkg::T_CFG] == cfg_pu) // R10
      else $error("output four pickup setting ignored");
   chk_recloser_route: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n) !rcl_on |=> !o_out.recloser_contact) // R7
      else $error("contact routed to recloser while off");
   chk_z1ext_trip: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n) z1ext |=> !o_out.brk1_open_to_scheme) // R9
      else $error("breaker timer used in extension trip");
   chk_timer_ranges: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n) trip_pu >= 8'h01 && trip_pu <= 8'h32
      && weak_pu >= 8'h08 && weak_pu <= 8'h63 && ro_dly >= 8'h0a
      && ro_dly <= 8'h64 && brk1_pu <= 8'hc8) // R13 R16 R18 R1
      else $error("timer setting out of range");
   chk_pickup_wait: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n) $rose(tout[rslt_pkg::T_BRK1])
      |-> $past(cnt[rslt_pkg::T_BRK1]) >= $past(brk1_pu)) // R5 R21
      else $error("breaker timer picked up early");
   chk_seal_needs_it: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n) !it |=> !o_out.trip_bus_seal) // R19
      else $error("seal-in without supervision");
   chk_event_tag: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n) $changed(o_out.brk1_coord_timer)
      |-> o_event.brk1_change) // R6
      else $error("breaker change without event");
   // a timer output only takes its input's level
   chk_cfg_follow: assert property (@(posedge i_mclk) // R5
      disable iff (!i_rst_n) $changed(tout[rslt_pkg::T_CFG])
      |-> tout[rslt_pkg::T_CFG] == $past(tin[rslt_pkg::T_CFG]))
      else $error("output four off its input");
   // the seal holds while supervision stays up
   chk_seal_hold: assert property (@(posedge i_mclk) // R19
      disable iff (!i_rst_n) it && o_out.trip_bus_seal
      |=> o_out.trip_bus_seal)
      else $error("seal-in dropped");
   chk_stamp_order: assert property (@(posedge i_mclk) // R6
      disable iff (!i_rst_n) o_event.stamp_ms >= $past(o_event.stamp_ms))
      else $error("event stamp ran backwards");
   cov_brk1_pickup: cover property (@(posedge i_mclk)
      disable iff (!i_rst_n) $rose(o_out.brk1_coord_timer));
   cov_event: cover property (@(posedge i_mclk)
      disable iff (!i_rst_n) o_event.valid && o_event.brk2_change);
   cov_cfg_fixed: cover property (@(posedge i_mclk)
      disable iff (!i_rst_n) out4_sel == 3'h3 ##1 $fell(tout[2]));
   // routing and seal-in seen
   cov_recloser: cover property (@(posedge i_mclk)
      disable iff (!i_rst_n) o_out.recloser_contact);
   cov_sealed: cover property (@(posedge i_mclk)
      disable iff (!i_rst_n) o_out.trip_bus_seal && !i_sch.trip_request);
endmodule

/* File: testbench/rslt_brk_model.sv */
// Purpose: breaker model that drives the b-contacts of two breakers
// Assumes: a b-contact is high while its breaker is open
// Notes: i_lag of 0 answers promptly, larger values model a slow breaker
`timescale 1ns/1ps
module rslt_brk_model (
   input wire logic i_mclk,
   input wire logic [1:0] i_open_cmd,
   input wire logic [7:0] i_lag,
   output logic [1:0] o_contact
);
   logic [7:0] cnt;
   initial o_contact = 2'h0;
   initial cnt = 8'h00;
   // b-contacts follow the main contacts after the mechanical lag
   always @(posedge i_mclk)
   begin
      if (i_open_cmd == o_contact)
         cnt <= 8'h00;
      else if (cnt >= i_lag)
      begin
         o_contact <= i_open_cmd;
         cnt <= 8'h00;
      end
      else
         cnt <= cnt + 8'h01;
   end
endmodule

/* File: testbench/testbench.sv */
// Purpose: self-checking bench for the scheme logic timers
// Assumes: tick shortened to 4 clocks, so 1 ms is 4 cycles
// Notes: reads and breaker events are checked from queues by a monitor
`timescale 1ns/1ps
module testbench;
   localparam int tick_n = 4;
   logic i_mclk, i_rst_n, i_wr, i_rd, i_trip_supervision_detector;
   logic rd_d, rc;
   logic [3:0] i_addr;
   logic [7:0] i_wdata, o_rdata, lag, rv;
   logic [15:0] lm;
   logic [1:0] cmd, contact, exp_ev;
   logic [6:0] tmr;
   logic [31:0] lfsr;
   rslt_pkg::rslt_in_type i_sch;
   rslt_pkg::rslt_out_type o_out;
   rslt_pkg::rslt_event_type o_event;
   logic [7:0] rd_q[$];
   logic [1:0] ev_q[$];
   int err_total, compares, cyc;
   int tids[4] = '{rslt_pkg::T_TRIP, rslt_pkg::T_PERM, rslt_pkg::T_WEAK,
      rslt_pkg::T_RO};
   int pu_t[4] = '{2, 4, 9, 11};
   int do_t[4] = '{0, 3, 0, 0};
   logic [7:0] md[5] = '{8'h00, 8'h01, 8'h03, 8'h06, 8'h00};
   logic [7:0] sc[5] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h05};

   // timer outputs gathered in slot order
   assign tmr = {o_out.remote_open_timer, o_out.weak_infeed_timer,
      o_out.permissive_coord_timer, o_out.trip_integrator_timer,
      o_out.cfg_out_four, o_out.brk2_coord_timer, o_out.brk1_coord_timer};

   // clock
   initial
   begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end

   rslt_timers #(.P_TICK_CYCLES(tick_n)) i_dut (.i_mclk(i_mclk),
      .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .i_contact_input_one(contact[0]),
      .i_contact_input_two(contact[1]),
      .i_trip_supervision_detector(i_trip_supervision_detector),
      .i_sch(i_sch), .o_rdata(o_rdata), .o_out(o_out), .o_event(o_event));

   rslt_brk_model i_brk (.i_mclk(i_mclk), .i_open_cmd(cmd), .i_lag(lag),
      .o_contact(contact));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // legal range per setting index as {min, max}
   function automatic logic [15:0] lim(input int a);
      case (a)
         0, 1, 2, 3: return 16'h00c8;
         4, 5: return 16'h0064;
         7: return 16'h0132;
         8, 9: return 16'h0032;
         10: return 16'h0863;
         12: return 16'h0a64;
         default: return 16'h0000;
      endcase
   endfunction

   function automatic logic [7:0] rst_val(input int a);
      case (a)
         7: return 8'h01;
         10: return 8'h08;
         12: return 8'h28;
         default: return 8'h00;
      endcase
   endfunction

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_rd <= 1'b0;
      i_addr <= a;
      i_wdata <= d;
   endtask

   task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_wr <= 1'b0;
      i_addr <= a;
      rd_q.push_back(exp);
   endtask

   task automatic bus_idle();
      @(posedge i_mclk);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask

   task automatic drive(input int t, input logic v);
      case (t)
         rslt_pkg::T_CFG: i_sch.cfg_out_in <= v;
         rslt_pkg::T_TRIP: i_sch.trip_integrator_in <= v;
         rslt_pkg::T_PERM: i_sch.permissive_in <= v;
         rslt_pkg::T_WEAK: i_sch.weak_infeed_in <= v;
         default: i_sch.remote_open_in <= v;
      endcase
   endtask

   // waits for a timer to flip and checks the latency in clock cycles
   task automatic measure(input int t, input int dly, input int extra);
      logic v0;
      int k;
      v0 = tmr[t];
      k = 0;
      while (tmr[t] === v0 && k < 1200)
      begin
         @(posedge i_mclk);
         #1;
         k++;
      end
      check(k >= tick_n * dly + 1 + extra &&
         k <= tick_n * dly + 7 + extra, 1);
      settle(3);
   endtask

   // monitor: oldest noted read and breaker event against the outputs
   always @(posedge i_mclk)
   begin
      rd_d <= i_rd;
      cyc <= cyc + int'(i_rst_n);
      if (rd_d === 1'b1)
         check(o_rdata, rd_q.pop_front());
      if (o_event.valid === 1'b1)
      begin
         exp_ev = (ev_q.size() > 0) ? ev_q.pop_front() : 2'bxx;
         check({o_event.brk2_change, o_event.brk2_change ?
            o_event.brk2_open : o_event.brk1_open}, exp_ev);
         check(o_event.stamp_ms * tick_n < cyc &&
            cyc <= o_event.stamp_ms * tick_n + tick_n, 1);
      end
   end

   // watchdog
   initial
   begin
      repeat (40000) @(posedge i_mclk);
      err_total++;
      finish_test();
   end

   initial
   begin
      i_rst_n = 1'b0;
      {i_wr, i_rd, rd_d, i_trip_supervision_detector} = 4'h0;
      {i_addr, i_wdata, lag, cmd} = 22'h000000;
      i_sch = '0;
      lfsr = 32'h00007db5;
      repeat (16) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      @(posedge i_mclk);
      for (int a = 0; a < 16; a++)
         reg_rd(a[3:0], rst_val(a));
      // clamping and random in-range settings
      for (int a = 0; a < 13; a++)
         if (lim(a) != 16'h0000)
         begin
            lm = lim(a);
            lfsr = next_rand(lfsr);
            rv = lm[15:8] + lfsr[7:0] % (lm[7:0] - lm[15:8] + 1);
            reg_wr(a[3:0], 8'hff);
            reg_rd(a[3:0], lm[7:0]);
            reg_wr(a[3:0], 8'h00);
            reg_rd(a[3:0], lm[15:8]);
            reg_wr(a[3:0], rv);
            reg_rd(a[3:0], rv);
         end
      reg_wr(rslt_pkg::A_STATUS, 8'hff);
      reg_rd(rslt_pkg::A_STATUS, 8'h00);
      // breaker one: pickup, interrupted dropout, dropout
      reg_wr(rslt_pkg::A_BRK1_PU, 8'h05);
      reg_wr(rslt_pkg::A_BRK1_DO, 8'h0a);
      reg_wr(rslt_pkg::A_BRK2_PU, 8'h03);
      reg_wr(rslt_pkg::A_BRK2_DO, 8'h00);
      bus_idle();
      @(posedge i_mclk);
      cmd[0] <= 1'b1;
      ev_q.push_back(2'b01);
      measure(rslt_pkg::T_BRK1, 5, 3);
      @(posedge i_mclk);
      cmd[0] <= 1'b0;
      repeat (20) @(posedge i_mclk);
      cmd[0] <= 1'b1;
      settle(60);
      check(tmr[rslt_pkg::T_BRK1], 1'b1);
      @(posedge i_mclk);
      cmd[0] <= 1'b0;
      ev_q.push_back(2'b00);
      measure(rslt_pkg::T_BRK1, 10, 3);
      // breaker two behind a slow breaker
      @(posedge i_mclk);
      lfsr = next_rand(lfsr);
      rv = 8'h08 + {5'h00, lfsr[2:0]};
      lag <= rv;
      cmd[1] <= 1'b1;
      ev_q.push_back(2'b11);
      measure(rslt_pkg::T_BRK2, 3, 3 + rv);
      @(posedge i_mclk);
      cmd[1] <= 1'b0;
      ev_q.push_back(2'b10);
      measure(rslt_pkg::T_BRK2, 0, 3 + rv);
      // contact routing per recloser mode and scheme
      for (int i = 0; i < 5; i++)
      begin
         reg_wr(rslt_pkg::A_RCL_MODE, md[i]);
         reg_wr(rslt_pkg::A_SCHEME, sc[i]);
         bus_idle();
         rc = (md[i] == 8'h03 || md[i] == 8'h06);
         @(posedge i_mclk);
         lag <= 8'h00;
         cmd[0] <= 1'b1;
         ev_q.push_back(2'b01);
         measure(rslt_pkg::T_BRK1, 5, 3);
         check(o_out.recloser_contact, rc);
         check(o_out.brk1_open_to_scheme, !rc && !sc[i][0]);
         check(o_out.zone2_ground_unit, sc[i][0] ? 2'b00 : sc[i][2:1]);
         @(posedge i_mclk);
         cmd[0] <= 1'b0;
         ev_q.push_back(2'b00);
         measure(rslt_pkg::T_BRK1, 10, 3);
      end
      // output four delays for each usage
      reg_wr(rslt_pkg::A_CFG_PU, 8'h03);
      reg_wr(rslt_pkg::A_CFG_DO, 8'h06);
      for (int u = 0; u < 6; u++)
      begin
         reg_wr(rslt_pkg::A_OUT4_SEL, u[7:0]);
         bus_idle();
         @(posedge i_mclk);
         drive(rslt_pkg::T_CFG, 1'b1);
         measure(rslt_pkg::T_CFG, (u > 0 && u < 5) ? 3 : 0, 0);
         @(posedge i_mclk);
         drive(rslt_pkg::T_CFG, 1'b0);
         measure(rslt_pkg::T_CFG, (u == 1 || u == 2) ? 6 :
            (u == 3 || u == 4) ? 25 : 0, 0);
      end
      // remote-open disabled, then the other scheme timers
      reg_wr(rslt_pkg::A_TRIP_PU, 8'h02);
      reg_wr(rslt_pkg::A_PERM_PU, 8'h04);
      reg_wr(rslt_pkg::A_PERM_DO, 8'h03);
      reg_wr(rslt_pkg::A_WEAK_PU, 8'h09);
      reg_wr(rslt_pkg::A_RO_DLY, 8'h0b);
      reg_wr(rslt_pkg::A_RO_EN, 8'h00);
      bus_idle();
      @(posedge i_mclk);
      drive(rslt_pkg::T_RO, 1'b1);
      settle(100);
      check(tmr[rslt_pkg::T_RO], 1'b0);
      @(posedge i_mclk);
      drive(rslt_pkg::T_RO, 1'b0);
      reg_wr(rslt_pkg::A_RO_EN, 8'h01);
      bus_idle();
      for (int i = 0; i < 4; i++)
      begin
         @(posedge i_mclk);
         drive(tids[i], 1'b1);
         measure(tids[i], pu_t[i], 0);
         reg_rd(rslt_pkg::A_STATUS, 8'h01 << tids[i]);
         bus_idle();
         @(posedge i_mclk);
         drive(tids[i], 1'b0);
         measure(tids[i], do_t[i], 0);
      end
      // seal-in gated by the supervision detector
      @(posedge i_mclk);
      i_sch.trip_request <= 1'b1;
      settle(8);
      check({o_out.trip_bus_seal, o_out.distance_supervision}, 2'b00);
      @(posedge i_mclk);
      i_trip_supervision_detector <= 1'b1;
      settle(8);
      @(posedge i_mclk);
      i_sch.trip_request <= 1'b0;
      settle(8);
      check({o_out.trip_bus_seal, o_out.distance_supervision}, 2'b11);
      @(posedge i_mclk);
      i_trip_supervision_detector <= 1'b0;
      settle(8);
      check({o_out.trip_bus_seal, o_out.distance_supervision}, 2'b00);
      check(ev_q.size() + rd_q.size(), 0);
      finish_test();
   end
endmodule
